/* design/async_serial_port_pkg.sv */
// Operation
// - Seven or eight data bits per character
// - Bits always travel least significant first
// - Own 5-bit counter divides base clock
// - Transmitter and receiver run independently
// - Base clock chosen from four sources
// - Stopped clock freezes state and pin
// - Enables synchronised to base clock; wait two
// - Finished character moves into receive buffer
// - Seven-bit mode clears buffer bit seven
// - Overrun leaves receive buffer untouched
// - Receive buffer read-only, all ones at reset
// - Writing transmit shift starts a frame
// - Power off stops and resets internals
// - Clearing an enable resets that direction
// - Power off holds receive input high
// - Parity field: none, zero, odd, even
// - Mode register resets to 01h, bit0 one
// - Zero parity reception is never checked
// - Length bit: clear seven, set eight
// - One or two stop bits sent; receive one
// - Error flags clear on read or disable
package async_serial_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] MODE_OFFSET = 16'hff70;
  localparam logic [15:0] BAUD_OFFSET = 16'hff74;
  localparam logic [15:0] ERROR_OFFSET = 16'hff78;
  localparam logic [15:0] RXBUF_OFFSET = 16'hff7c;
  localparam logic [15:0] TXSHIFT_OFFSET = 16'hff80;
  localparam logic [15:0] STATUS_OFFSET = 16'hff84;

  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] BAUD_RESET = 8'h1f;
  localparam logic [7:0] RXBUF_RESET = 8'hff;
  localparam logic [7:0] TXSHIFT_RESET = 8'hff;

  localparam int MODE_POWER_BIT = 7;
  localparam int MODE_TXE_BIT = 6;
  localparam int MODE_RXE_BIT = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_LEN_BIT = 2;
  localparam int MODE_STOP_BIT = 1;
  localparam int BAUD_SRC_HI = 7;
  localparam int BAUD_SRC_LO = 6;
  localparam int BAUD_DIV_HI = 4;
  localparam int ERR_PARITY_BIT = 2;
  localparam int ERR_FRAMING_BIT = 1;
  localparam int ERR_OVERRUN_BIT = 0;

  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ZERO = 2'h1;
  localparam logic [1:0] PARITY_ODD = 2'h2;
  localparam logic [1:0] PARITY_EVEN = 2'h3;

  // Parity bit for a character of seven or eight bits
  function automatic logic parity_bit(input logic [7:0] d, input logic len8,
                                      input logic [1:0] ps);
    logic x;
    x = ^(len8 ? d : {1'b0, d[6:0]});
    unique case (ps)
      PARITY_ODD: parity_bit = ~x;
      PARITY_EVEN: parity_bit = x;
      default: parity_bit = 1'b0;
    endcase
  endfunction

endpackage

/* design/async_serial_port.sv */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module async_serial_port
  import async_serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_timer_tick,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic tx_complete_irq,
  output logic rx_complete_irq,
  output logic rx_error_irq
);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

  logic [7:0] serial_mode_control_reg;
  logic [7:0] baud_divider_control_reg;
  logic [7:0] receive_buffer_reg;
  logic [7:0] transmit_shift_reg;
  logic [2:0] receive_error_status_reg;
  logic [7:0] receive_shifter_reg;
  logic rx_full_reg;
  logic [5:0] presc_reg;
  logic base_tick_reg;
  logic [4:0] brg_cnt_reg;
  logic half_tick_reg;
  logic txe_s1_reg, txe_s2_reg, rxe_s1_reg, rxe_s2_reg;
  logic tx_phase_reg, tx_pending_reg, tx_stop2_reg;
  logic [2:0] tx_cnt_reg;
  tx_state_t tx_state_reg;
  logic rx_s1_reg, rx_s2_reg, rx_prev_reg, rx_phase_reg, rx_par_err_reg;
  logic [2:0] rx_cnt_reg;
  rx_state_t rx_state_reg;

  logic port_power_enable, transmit_enable_bit, receive_enable_bit, char_length_bit;
  logic stop_length_bit, tx_run, rx_run, tx_bit_tick, rx_line, rx_sample, rx_complete;
  logic [1:0] parity_sel;
  logic accept, wr_mode, wr_baud, wr_tx, rd_err, rd_rxbuf;
  logic [2:0] last_bit;
  logic [4:0] rx_brg_cnt_reg;
  logic rx_half_reg;

  // Counter end test shared by the transmit and receive dividers
  function automatic logic div_wrap(input logic [4:0] cnt, input logic [4:0] k);
    div_wrap = ({1'b0, cnt} + 6'h1) >= {1'b0, k};
  endfunction

  assign port_power_enable = serial_mode_control_reg[MODE_POWER_BIT];
  assign transmit_enable_bit = serial_mode_control_reg[MODE_TXE_BIT];
  assign receive_enable_bit = serial_mode_control_reg[MODE_RXE_BIT];
  assign parity_sel = serial_mode_control_reg[MODE_PAR_HI:MODE_PAR_LO];
  assign char_length_bit = serial_mode_control_reg[MODE_LEN_BIT];
  assign stop_length_bit = serial_mode_control_reg[MODE_STOP_BIT];
  assign last_bit = char_length_bit ? 3'h7 : 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave, one wait state per access
  assign accept = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_mode = accept & avs_write & avs_byteenable[0] & (avs_address == MODE_OFFSET);
  assign wr_baud = accept & avs_write & avs_byteenable[0] & (avs_address == BAUD_OFFSET);
  assign wr_tx = accept & avs_write & avs_byteenable[0] & (avs_address == TXSHIFT_OFFSET);
  assign rd_err = accept & avs_read & (avs_address == ERROR_OFFSET);
  assign rd_rxbuf = accept & avs_read & (avs_address == RXBUF_OFFSET);

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else if (accept)
      avs_waitrequest <= 1'b1;
    else if (avs_read | avs_write)
    begin
      avs_waitrequest <= 1'b0;
      unique case (avs_address)
        MODE_OFFSET: avs_readdata <= {24'h0, serial_mode_control_reg};
        BAUD_OFFSET: avs_readdata <= {24'h0, baud_divider_control_reg};
        ERROR_OFFSET: avs_readdata <= {29'h0, receive_error_status_reg};
        RXBUF_OFFSET: avs_readdata <= {24'h0, receive_buffer_reg};
        STATUS_OFFSET: avs_readdata <= {30'h0, tx_state_reg != TX_IDLE, rx_full_reg};
        default: avs_readdata <= 32'h0;
      endcase
    end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      serial_mode_control_reg <= MODE_RESET;
    else if (wr_mode)
      serial_mode_control_reg <= {avs_writedata[7:1], 1'b1};

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      baud_divider_control_reg <= BAUD_RESET;
    else if (wr_baud)
      baud_divider_control_reg <= {avs_writedata[7:6], 1'b0, avs_writedata[4:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Base clock and baud counter; power off holds the tick low
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      presc_reg <= 6'h0;
      base_tick_reg <= 1'b0;
    end
    else
    begin
      presc_reg <= presc_reg + 6'h1;
      if (!port_power_enable)
        base_tick_reg <= 1'b0;
      else
        unique case (baud_divider_control_reg[BAUD_SRC_HI:BAUD_SRC_LO])
          2'h0: base_tick_reg <= ext_timer_tick;
          2'h1: base_tick_reg <= &presc_reg[1:0];
          2'h2: base_tick_reg <= &presc_reg[3:0];
          2'h3: base_tick_reg <= &presc_reg;
        endcase
    end

  // Half-bit tick every k base ticks; a bit lasts two of them
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      brg_cnt_reg <= 5'h0;
      half_tick_reg <= 1'b0;
    end
    else
    begin
      half_tick_reg <= 1'b0;
      if (!port_power_enable)
        brg_cnt_reg <= 5'h0;
      else if (base_tick_reg)
      begin
        if (div_wrap(brg_cnt_reg, baud_divider_control_reg[BAUD_DIV_HI:0]))
        begin
          brg_cnt_reg <= 5'h0;
          half_tick_reg <= 1'b1;
        end
        else
          brg_cnt_reg <= brg_cnt_reg + 5'h1;
      end
    end

  // Enables pass two base-clock stages, so a re-enable before the next base tick finds them still set and runs at once
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      txe_s1_reg <= 1'b0;
      txe_s2_reg <= 1'b0;
      rxe_s1_reg <= 1'b0;
      rxe_s2_reg <= 1'b0;
    end
    else if (!port_power_enable)
    begin
      txe_s1_reg <= 1'b0;
      txe_s2_reg <= 1'b0;
      rxe_s1_reg <= 1'b0;
      rxe_s2_reg <= 1'b0;
    end
    else if (base_tick_reg)
    begin
      txe_s1_reg <= transmit_enable_bit;
      txe_s2_reg <= txe_s1_reg;
      rxe_s1_reg <= receive_enable_bit;
      rxe_s2_reg <= rxe_s1_reg;
    end

  assign tx_run = port_power_enable & transmit_enable_bit & txe_s2_reg;
  assign rx_run = port_power_enable & receive_enable_bit & rxe_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      transmit_shift_reg <= TXSHIFT_RESET;
    else if (!port_power_enable || !transmit_enable_bit)
      transmit_shift_reg <= TXSHIFT_RESET;
    else if (wr_tx && tx_run)
      transmit_shift_reg <= avs_writedata[7:0];

  assign tx_bit_tick = half_tick_reg & tx_phase_reg;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      tx_state_reg <= TX_IDLE;
      serial_tx_pin <= 1'b1;
      tx_phase_reg <= 1'b0;
      tx_pending_reg <= 1'b0;
      tx_stop2_reg <= 1'b0;
      tx_cnt_reg <= 3'h0;
      tx_complete_irq <= 1'b0;
    end
    else
    begin
      tx_complete_irq <= 1'b0;
      if (half_tick_reg)
        tx_phase_reg <= ~tx_phase_reg;
      if (!tx_run)
      begin
        tx_state_reg <= TX_IDLE;
        serial_tx_pin <= 1'b1;
        tx_pending_reg <= 1'b0;
      end
      else
      begin
        if (wr_tx)
          tx_pending_reg <= 1'b1;
        unique case (tx_state_reg)
          TX_IDLE:
            if (tx_pending_reg && tx_bit_tick)
            begin
              serial_tx_pin <= 1'b0;
              tx_pending_reg <= 1'b0;
              tx_state_reg <= TX_START;
            end
          TX_START:
            if (tx_bit_tick)
            begin
              serial_tx_pin <= transmit_shift_reg[0];
              tx_cnt_reg <= 3'h0;
              tx_state_reg <= TX_DATA;
            end
          TX_DATA:
            if (tx_bit_tick)
            begin
              if (tx_cnt_reg != last_bit)
              begin
                tx_cnt_reg <= tx_cnt_reg + 3'h1;
                serial_tx_pin <= transmit_shift_reg[tx_cnt_reg + 3'h1];
              end
              else if (parity_sel != PARITY_NONE)
              begin
                serial_tx_pin <= parity_bit(transmit_shift_reg, char_length_bit,
                                            parity_sel);
                tx_state_reg <= TX_PARITY;
              end
              else
              begin
                serial_tx_pin <= 1'b1;
                tx_stop2_reg <= 1'b0;
                tx_state_reg <= TX_STOP;
              end
            end
          TX_PARITY:
            if (tx_bit_tick)
            begin
              serial_tx_pin <= 1'b1;
              tx_stop2_reg <= 1'b0;
              tx_state_reg <= TX_STOP;
            end
          TX_STOP:
            if (tx_bit_tick)
            begin
              if (stop_length_bit && !tx_stop2_reg)
                tx_stop2_reg <= 1'b1;
              else
              begin
                tx_state_reg <= TX_IDLE;
                tx_complete_irq <= 1'b1;
              end
            end
        endcase
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver; only the second synchroniser stage is looked at
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg <= serial_rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_line;
    end

  assign rx_line = port_power_enable ? rx_s2_reg : 1'b1;
  assign rx_sample = rx_half_reg & rx_phase_reg;

  // Own half-bit count restarted at the start edge, so bits are sampled at their centres
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_brg_cnt_reg <= 5'h0;
      rx_half_reg <= 1'b0;
    end
    else
    begin
      rx_half_reg <= 1'b0;
      if (!rx_run || rx_state_reg == RX_IDLE)
        rx_brg_cnt_reg <= 5'h0;
      else if (base_tick_reg)
      begin
        if (div_wrap(rx_brg_cnt_reg, baud_divider_control_reg[BAUD_DIV_HI:0]))
        begin
          rx_brg_cnt_reg <= 5'h0;
          rx_half_reg <= 1'b1;
        end
        else
          rx_brg_cnt_reg <= rx_brg_cnt_reg + 5'h1;
      end
    end
  assign rx_complete = rx_run & (rx_state_reg == RX_STOP) & rx_sample;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_state_reg <= RX_IDLE;
      rx_phase_reg <= 1'b0;
      rx_cnt_reg <= 3'h0;
      rx_par_err_reg <= 1'b0;
      receive_shifter_reg <= 8'h0;
    end
    else if (!rx_run)
      rx_state_reg <= RX_IDLE;
    else
    begin
      if (rx_half_reg)
        rx_phase_reg <= ~rx_phase_reg;
      unique case (rx_state_reg)
        RX_IDLE:
          if (rx_prev_reg && !rx_line)
          begin
            rx_state_reg <= RX_START;
            rx_par_err_reg <= 1'b0;
            receive_shifter_reg <= 8'h0;
          end
        RX_START:
          if (rx_half_reg)
          begin
            rx_phase_reg <= 1'b0;
            rx_cnt_reg <= 3'h0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_sample)
          begin
            receive_shifter_reg[rx_cnt_reg] <= rx_line;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == last_bit)
              rx_state_reg <= (parity_sel != PARITY_NONE) ? RX_PARITY : RX_STOP;
          end
        RX_PARITY:
          if (rx_sample)
          begin
            rx_par_err_reg <= parity_sel[1] && (rx_line != parity_bit(receive_shifter_reg,
                              char_length_bit, parity_sel));
            rx_state_reg <= RX_STOP;
          end
        RX_STOP:
          if (rx_sample)
            rx_state_reg <= RX_IDLE;
      endcase
    end

  // Buffer hand-off; a set in the same cycle as a read wins
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      receive_buffer_reg <= RXBUF_RESET;
      rx_full_reg <= 1'b0;
      rx_complete_irq <= 1'b0;
    end
    else
    begin
      rx_complete_irq <= 1'b0;
      if (!port_power_enable)
      begin
        receive_buffer_reg <= RXBUF_RESET;
        rx_full_reg <= 1'b0;
      end
      else if (rx_complete && !rx_full_reg)
      begin
        receive_buffer_reg <= char_length_bit ? receive_shifter_reg
                              : {1'b0, receive_shifter_reg[6:0]};
        rx_full_reg <= 1'b1;
        rx_complete_irq <= 1'b1;
      end
      else if (rd_rxbuf || !receive_enable_bit)
        rx_full_reg <= 1'b0;
    end

  // Read clears only what the snapshot showed, so a fresh error survives
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      receive_error_status_reg <= 3'h0;
      rx_error_irq <= 1'b0;
    end
    else if (!port_power_enable || !receive_enable_bit)
    begin
      receive_error_status_reg <= 3'h0;
      rx_error_irq <= 1'b0;
    end
    else
    begin
      receive_error_status_reg <= (receive_error_status_reg
                                   & ~(rd_err ? avs_readdata[2:0] : 3'h0))
                                  | (rx_complete ? {rx_par_err_reg, !rx_line, rx_full_reg}
                                     : 3'h0);
      rx_error_irq <= rx_complete & (rx_par_err_reg | !rx_line | rx_full_reg);
    end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_mode_bit0;
    serial_mode_control_reg[0];
  endproperty
  a_mode_bit0: assert property (p_mode_bit0) else $error("mode bit0 not one");

  property p_bus_one_wait;
    (avs_read | avs_write) && avs_waitrequest && !$past(accept) |=> !avs_waitrequest;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("no answer");

  property p_seven_bit_msb;
    rx_complete && !rx_full_reg && !char_length_bit && port_power_enable
      |=> !receive_buffer_reg[7] && rx_full_reg;
  endproperty
  a_seven_bit_msb: assert property (p_seven_bit_msb) else $error("msb set");

  property p_overrun_keeps;
    rx_complete && rx_full_reg
      |=> $stable(receive_buffer_reg) && receive_error_status_reg[ERR_OVERRUN_BIT];
  endproperty
  a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun lost");

  property p_power_off;
    !port_power_enable |=> receive_buffer_reg == RXBUF_RESET
      && receive_error_status_reg == 3'h0 && transmit_shift_reg == TXSHIFT_RESET;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power off not reset");

  property p_tx_start_low;
    tx_run && tx_state_reg == TX_IDLE && tx_pending_reg && tx_bit_tick
      |=> !serial_tx_pin ##1 !serial_tx_pin;
  endproperty
  a_tx_start_low: assert property (p_tx_start_low) else $error("no start bit");

  property p_tx_idle_high;
    tx_state_reg == TX_IDLE && $past(tx_state_reg) == TX_IDLE |-> serial_tx_pin;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high) else $error("idle low");

  property p_zero_parity;
    parity_sel == PARITY_ZERO && rx_complete |=> !receive_error_status_reg[ERR_PARITY_BIT];
  endproperty
  a_zero_parity: assert property (p_zero_parity) else $error("zero parity checked");

  property p_tx_disable;
    !transmit_enable_bit |=> tx_state_reg == TX_IDLE && serial_tx_pin;
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("tx not reset");

  c_tx_done: cover property (tx_complete_irq);
  c_rx_done: cover property (rx_complete_irq);
  c_overrun: cover property (rx_complete && rx_full_reg);
  c_parity_err: cover property (rx_complete && rx_par_err_reg);

endmodule // async_serial_port

/* verification/remote_station.sv */
`timescale 1ns/1ps
module remote_station
#(
  parameter int BIT_CYC = 64
)
(
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [10:0] frame_bits;
  int n_frames;

  initial
  begin
    line_out = 1'b1;
    frame_bits = '1;
    n_frames = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sender: caller gives data, parity and stop bits, LSB first
  task automatic send(input logic [10:0] bits, input int n);
    @(posedge clk);
    line_out <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    // Idle gap so the far end sees a full stop bit and a quiet line
    line_out <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: samples bit centres; trailing bits show stop and idle
  initial
  begin
    forever
    begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 11; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        frame_bits[i] = line_in;
      end
      n_frames++;
    end
  end
endmodule // remote_station

/* verification/async_serial_port_tb.sv */
`timescale 1ns/1ps
module async_serial_port_tb
  import async_serial_port_pkg::*;
;
  // clk/4 base, k = 8: one bit is 64 clocks
  localparam int BIT = 64;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic ext_timer_tick, rx_line, tx_line, tx_irq, rx_irq, err_irq, tick_on;
  int n_errors, n_compared, n_txc, n_rxc, n_erc, cyc;

  async_serial_port async_serial_port_i (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_timer_tick(ext_timer_tick), .serial_rx_pin(rx_line),
    .serial_tx_pin(tx_line), .tx_complete_irq(tx_irq),
    .rx_complete_irq(rx_irq), .rx_error_irq(err_irq));
  remote_station #(.BIT_CYC(BIT)) remote_station_i (.clk(clk),
    .line_in(tx_line), .line_out(rx_line));

  always #4 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    n_txc += (tx_irq === 1'b1);
    n_rxc += (rx_irq === 1'b1);
    n_erc += (err_irq === 1'b1);
    // External base tick, one pulse every four clocks while enabled
    ext_timer_tick <= tick_on && (cyc % 4 == 0);
    // Ceiling well above the roughly 15k cycles the tests need
    if (cyc == 40000)
    begin
      n_errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(q, exp);
  endtask

  function automatic int evc(input int sel);
    evc = (sel == 0) ? n_txc : (sel == 1) ? n_rxc : remote_station_i.n_frames;
  endfunction

  task automatic wait_ev(input int sel, input int old);
    int g;
    g = 0;
    while (evc(sel) <= old && g < 3000)
    begin
      @(posedge clk);
      g++;
    end
    check({31'h0, evc(sel) > old}, 32'h1);
  endtask

  // Expected line bits after the start bit; unused tail stays high
  function automatic logic [10:0] frame_of(input logic [7:0] d, input logic len8,
                                           input logic [1:0] par);
    logic [10:0] f;
    logic p;
    int n;
    f = '1;
    p = 1'b0;
    n = len8 ? 8 : 7;
    for (int i = 0; i < n; i++)
    begin
      f[i] = d[i];
      p ^= d[i];
    end
    if (par != 2'h0)
      f[n] = (par == 2'h2) ? ~p : (par == 2'h3) ? p : 1'b0;
    frame_of = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] d;
    logic [4:0] f5;
    logic held;
    int old, of;
    clk = 1'b0;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 16'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    tick_on = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(MODE_OFFSET, 32'h01);
    rd_chk(RXBUF_OFFSET, 32'hff);
    rd_chk(ERROR_OFFSET, 32'h00);
    rd_chk(16'hff90, 32'h00);
    wr(BAUD_OFFSET, 8'h48);
    rd_chk(BAUD_OFFSET, 32'h48);
    wr(MODE_OFFSET, 8'h80);
    rd_chk(MODE_OFFSET, 32'h81);
    wr(RXBUF_OFFSET, 8'h12);
    rd_chk(RXBUF_OFFSET, 32'hff);
    // Every parity code with both lengths; stop length follows length
    for (int m = 0; m < 8; m++)
    begin
      d = 8'hc5 + 8'(m * 37);
      f5 = {m[1:0], m[2], m[2], 1'b1};
      wr(MODE_OFFSET, {3'b100, f5});
      repeat (16) @(posedge clk);
      wr(MODE_OFFSET, {3'b110, f5});
      repeat (16) @(posedge clk);
      old = n_txc;
      of = remote_station_i.n_frames;
      wr(TXSHIFT_OFFSET, d);
      wait_ev(0, old);
      wait_ev(2, of);
      check({21'h0, remote_station_i.frame_bits},
            {21'h0, frame_of(d, m[2], m[1:0])});
      check({31'h0, tx_line}, 32'h1);
    end
    // Transmitter off: a write must not start a frame
    wr(MODE_OFFSET, 8'h81);
    old = n_txc;
    wr(TXSHIFT_OFFSET, 8'h00);
    repeat (800) @(posedge clk);
    check(n_txc, old);
    // Receive, odd parity, eight bits
    wr(MODE_OFFSET, 8'hb5);
    repeat (16) @(posedge clk);
    old = n_rxc;
    remote_station_i.send(frame_of(8'h3c, 1'b1, 2'h2), 9);
    wait_ev(1, old);
    rd_chk(RXBUF_OFFSET, 32'h3c);
    rd_chk(ERROR_OFFSET, 32'h00);
    old = n_erc;
    remote_station_i.send(frame_of(8'ha7, 1'b1, 2'h2) ^ 11'h100, 9);
    check(n_erc, old + 1);
    rd_chk(ERROR_OFFSET, 32'h04);
    rd_chk(ERROR_OFFSET, 32'h00);
    rd_chk(RXBUF_OFFSET, 32'ha7);
    // Two characters unread: second one is dropped
    remote_station_i.send(frame_of(8'h11, 1'b1, 2'h2), 9);
    remote_station_i.send(frame_of(8'h22, 1'b1, 2'h2), 9);
    rd_chk(RXBUF_OFFSET, 32'h11);
    rd_chk(ERROR_OFFSET, 32'h01);
    // Zero parity: a wrong parity bit is not flagged
    wr(MODE_OFFSET, 8'h81);
    repeat (16) @(posedge clk);
    wr(MODE_OFFSET, 8'had);
    repeat (16) @(posedge clk);
    old = n_erc;
    remote_station_i.send(frame_of(8'h96, 1'b1, 2'h1) ^ 11'h100, 9);
    check(n_erc, old);
    rd_chk(ERROR_OFFSET, 32'h00);
    rd_chk(RXBUF_OFFSET, 32'h96);
    // Seven bits: buffer bit 7 reads zero
    wr(MODE_OFFSET, 8'h81);
    repeat (16) @(posedge clk);
    wr(MODE_OFFSET, 8'ha1);
    repeat (16) @(posedge clk);
    remote_station_i.send(frame_of(8'hff, 1'b0, 2'h0), 8);
    rd_chk(RXBUF_OFFSET, 32'h7f);
    // Framing error then receiver off clears the flags
    old = n_erc;
    remote_station_i.send(frame_of(8'h5a, 1'b0, 2'h0) ^ 11'h080, 8);
    check(n_erc, old + 1);
    rd_chk(RXBUF_OFFSET, 32'h5a);
    wr(MODE_OFFSET, 8'h81);
    repeat (16) @(posedge clk);
    rd_chk(ERROR_OFFSET, 32'h00);
    // External tick as base clock; a stopped tick freezes the frame and the pin
    tick_on <= 1'b1;
    wr(BAUD_OFFSET, 8'h08);
    wr(MODE_OFFSET, 8'h85);
    repeat (16) @(posedge clk);
    wr(MODE_OFFSET, 8'hc5);
    repeat (16) @(posedge clk);
    old = n_txc;
    of = remote_station_i.n_frames;
    wr(TXSHIFT_OFFSET, 8'h6b);
    wait_ev(0, old);
    wait_ev(2, of);
    check({21'h0, remote_station_i.frame_bits},
          {21'h0, frame_of(8'h6b, 1'b1, 2'h0)});
    old = n_txc;
    wr(TXSHIFT_OFFSET, 8'h00);
    repeat (200) @(posedge clk);
    tick_on <= 1'b0;
    repeat (4) @(posedge clk);
    held = tx_line;
    repeat (600) @(posedge clk);
    check({31'h0, tx_line}, {31'h0, held});
    check(n_txc, old);
    // Power off resets the receive buffer and releases the pin
    wr(MODE_OFFSET, 8'h01);
    rd_chk(RXBUF_OFFSET, 32'hff);
    rd_chk(MODE_OFFSET, 32'h01);
    check({31'h0, tx_line}, 32'h1);
    stop_test();
  end
endmodule // async_serial_port_tb
